// ---- tsc_map.svh ----
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH

// Register byte offsets
`define TSC_OFF_CTRL       8'h00
`define TSC_OFF_STATUS     8'h04
`define TSC_OFF_THRESHOLD  8'h08

// Control register field positions
`define TSC_CTRL_DIV_HI    25
`define TSC_CTRL_DIV_LO    16
`define TSC_CTRL_ALARM_ENABLE      8
`define TSC_CTRL_PDN       7
`define TSC_CTRL_DCOR_HI   6
`define TSC_CTRL_DCOR_LO   2
`define TSC_CTRL_SRSTN     1
`define TSC_CTRL_SENSOR_CLOCK_ENABLE     0

// Status register field positions
`define TSC_ST_MAX_HI      30
`define TSC_ST_MAX_LO      24
`define TSC_ST_MIN_HI      22
`define TSC_ST_MIN_LO      16
`define TSC_ST_SCLK        15
`define TSC_ST_WE          10
`define TSC_ST_UPD         9
`define TSC_ST_ALARM_ACTIVE       8
`define TSC_ST_DATA_HI     6
`define TSC_ST_DATA_LO     0

// Threshold register field positions
`define TSC_THR_HI         6
`define TSC_THR_LO         0

// Reset values
`define TSC_RST_MAX        7'h00
`define TSC_RST_MIN        7'h7F
`define TSC_RST_DATA       7'h00
`define TSC_RST_THRESHOLD  7'h00
`define TSC_RST_DIV        10'h000

// Synchroniser depth for sensor pins
`define TSC_SYNC_STAGES    3

`endif

// ---- tsc_pkg.sv ----
package tsc_pkg;

   typedef logic [6:0] tsc_temp_t;

   typedef struct packed {
      logic [9:0] div;
      logic       alarmEnable;
      logic       powerUpN;
      logic [4:0] dcorrect;
      logic       sensorRstN;
      logic       sensorClockEnable;
   } tsc_ctrl_t;

   typedef struct packed {
      tsc_temp_t maxVal;
      tsc_temp_t minVal;
      logic      newSampleFlag;
      logic      alarmActive;
      tsc_temp_t data;
   } tsc_status_t;

   typedef enum {
      TSC_SEL_CTRL,
      TSC_SEL_STATUS,
      TSC_SEL_THRESHOLD,
      TSC_SEL_NONE
   } tsc_sel_t;

endpackage

// ---- tsc_sync.sv ----
`timescale 1ns/1ps
`include "tsc_map.svh"

// Three-stage pin synchroniser; output changes once stages two and three agree
module tsc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] stableOut
);

   logic [WIDTH-1:0] stage_ff [`TSC_SYNC_STAGES];
   logic [WIDTH-1:0] stable_ff;
   logic [WIDTH-1:0] nxt_stable;

   genvar g;
   generate
      for (g = 0; g < `TSC_SYNC_STAGES; g++) begin : gStage
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               stage_ff[g] <= '0;
            end else begin
               stage_ff[g] <= (g == 0) ? pinIn : stage_ff[(g == 0) ? 0 : g-1];
            end
         end
      end
   endgenerate

   always_comb begin
      nxt_stable = stable_ff;
      if (stage_ff[1] == stage_ff[2]) begin
         nxt_stable = stage_ff[2];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stable_ff <= '0;
      end else begin
         stable_ff <= nxt_stable;
      end
   end

   assign stableOut = stable_ff;

endmodule

// ---- tsc_temp_sensor.sv ----
`timescale 1ns/1ps
`include "tsc_map.svh"

module tsc_temp_sensor (
   input  wire logic        clk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Sensor side
   input  wire logic [6:0]  sensorData,
   input  wire logic        sensorValid,
   output logic             sensorClk,
   output logic             sensorRstN,
   output logic             sensorPdN,
   output logic [4:0]       sensorDcorrect,
   output logic             irq
);

   function automatic tsc_pkg::tsc_sel_t regSel(input logic [7:0] a);
      case (a)
         `TSC_OFF_CTRL:      regSel = tsc_pkg::TSC_SEL_CTRL;
         `TSC_OFF_STATUS:    regSel = tsc_pkg::TSC_SEL_STATUS;
         `TSC_OFF_THRESHOLD: regSel = tsc_pkg::TSC_SEL_THRESHOLD;
         default:            regSel = tsc_pkg::TSC_SEL_NONE;
      endcase
   endfunction

   // Readable words; reserved positions stay zero
   function automatic logic [31:0] ctrlWord(input tsc_pkg::tsc_ctrl_t c);
      ctrlWord = 32'h0000_0000;
      ctrlWord[`TSC_CTRL_DIV_HI:`TSC_CTRL_DIV_LO]   = c.div;
      ctrlWord[`TSC_CTRL_ALARM_ENABLE]                      = c.alarmEnable;
      ctrlWord[`TSC_CTRL_PDN]                       = c.powerUpN;
      ctrlWord[`TSC_CTRL_DCOR_HI:`TSC_CTRL_DCOR_LO] = c.dcorrect;
      ctrlWord[`TSC_CTRL_SRSTN]                     = c.sensorRstN;
      ctrlWord[`TSC_CTRL_SENSOR_CLOCK_ENABLE]                     = c.sensorClockEnable;
   endfunction

   function automatic logic [31:0] statusWord(
      input tsc_pkg::tsc_status_t s,
      input logic                 sclk
   );
      statusWord = 32'h0000_0000;
      statusWord[`TSC_ST_MAX_HI:`TSC_ST_MAX_LO]   = s.maxVal;
      statusWord[`TSC_ST_MIN_HI:`TSC_ST_MIN_LO]   = s.minVal;
      statusWord[`TSC_ST_SCLK]                    = sclk;
      statusWord[`TSC_ST_WE]                      = 1'b0;
      statusWord[`TSC_ST_UPD]                     = s.newSampleFlag;
      statusWord[`TSC_ST_ALARM_ACTIVE]                   = s.alarmActive;
      statusWord[`TSC_ST_DATA_HI:`TSC_ST_DATA_LO] = s.data;
   endfunction

   tsc_pkg::tsc_ctrl_t   ctrl_ff,      nxt_ctrl;
   tsc_pkg::tsc_status_t status_ff,    nxt_status;
   tsc_pkg::tsc_temp_t   threshold_ff, nxt_threshold;
   logic [31:0]          prdata_ff,    nxt_prdata;
   logic                 pready_ff,    nxt_pready;
   logic                 pslverr_ff,   nxt_pslverr;
   logic                 irq_ff,       nxt_irq;
   logic [9:0]           divCnt_ff,    nxt_divCnt;
   logic                 sclk_ff,      nxt_sclk;
   logic                 validLast_ff, nxt_validLast;

   logic [7:0]           syncOut;
   logic                 validSync;
   tsc_pkg::tsc_temp_t   dataSync;
   logic                 sample;
   logic                 access;
   logic                 wrAcc;
   logic                 rdAcc;
   tsc_pkg::tsc_sel_t    sel;
   logic                 wrCtrl;
   logic                 wrStat;
   logic                 wrThr;
   logic                 rdStat;

   tsc_sync #(
      .WIDTH(8)
   ) uSync (
      .clk      (clk),
      .rst_n    (rst_n),
      .pinIn    ({sensorValid, sensorData}),
      .stableOut(syncOut)
   );

   assign validSync = syncOut[7];
   assign dataSync  = syncOut[6:0];
   // One capture per sample strobe from the sensor
   assign sample    = validSync & ~validLast_ff;

   // Access taken in first access-phase cycle; pready follows one cycle later
   assign access = psel & penable & ~pready_ff;
   assign wrAcc  = access & pwrite;
   assign rdAcc  = access & ~pwrite;
   assign sel    = regSel(paddr);

   // Decoded register strobes
   assign wrCtrl = wrAcc & (sel == tsc_pkg::TSC_SEL_CTRL);
   assign wrStat = wrAcc & (sel == tsc_pkg::TSC_SEL_STATUS);
   assign wrThr  = wrAcc & (sel == tsc_pkg::TSC_SEL_THRESHOLD);
   assign rdStat = rdAcc & (sel == tsc_pkg::TSC_SEL_STATUS);

   // Sensor clock divider
   always_comb begin
      nxt_divCnt = divCnt_ff;
      nxt_sclk   = sclk_ff;
      if (!ctrl_ff.sensorClockEnable || ctrl_ff.div == 10'h000) begin
         nxt_divCnt = 10'h000;
         nxt_sclk   = 1'b0;
      end else if (divCnt_ff >= ctrl_ff.div - 10'h001) begin
         nxt_divCnt = 10'h000;
         nxt_sclk   = ~sclk_ff;
      end else begin
         nxt_divCnt = divCnt_ff + 10'h001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         divCnt_ff <= 10'h000;
         sclk_ff   <= 1'b0;
      end else begin
         divCnt_ff <= nxt_divCnt;
         sclk_ff   <= nxt_sclk;
      end
   end

   // Control register
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (wrCtrl) begin
         nxt_ctrl.div         = pwdata[`TSC_CTRL_DIV_HI:`TSC_CTRL_DIV_LO];
         nxt_ctrl.alarmEnable = pwdata[`TSC_CTRL_ALARM_ENABLE];
         nxt_ctrl.powerUpN    = pwdata[`TSC_CTRL_PDN];
         nxt_ctrl.dcorrect    = pwdata[`TSC_CTRL_DCOR_HI:`TSC_CTRL_DCOR_LO];
         nxt_ctrl.sensorRstN  = pwdata[`TSC_CTRL_SRSTN];
         nxt_ctrl.sensorClockEnable = pwdata[`TSC_CTRL_SENSOR_CLOCK_ENABLE];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= '0;
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   // Alarm threshold; bits above the value field are dropped
   always_comb begin
      nxt_threshold = threshold_ff;
      if (wrThr) begin
         nxt_threshold = pwdata[`TSC_THR_HI:`TSC_THR_LO];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         threshold_ff <= `TSC_RST_THRESHOLD;
      end else begin
         threshold_ff <= nxt_threshold;
      end
   end

   // Edge detect of the synchronised strobe; resets to the idle low level
   always_comb begin
      nxt_validLast = validSync;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         validLast_ff <= 1'b0;
      end else begin
         validLast_ff <= nxt_validLast;
      end
   end

   // Status register
   always_comb begin
      nxt_status = status_ff;
      if (sample) begin
         // Unsigned 7-bit compare throughout
         nxt_status.data = dataSync;
         if (dataSync > status_ff.maxVal) begin
            nxt_status.maxVal = dataSync;
         end
         if (dataSync < status_ff.minVal) begin
            nxt_status.minVal = dataSync;
         end
      end
      if (wrStat) begin
         if (pwdata[`TSC_ST_WE]) begin
            // Software load wins over a sample in the same cycle
            nxt_status.maxVal = pwdata[`TSC_ST_MAX_HI:`TSC_ST_MAX_LO];
            nxt_status.minVal = pwdata[`TSC_ST_MIN_HI:`TSC_ST_MIN_LO];
         end
         if (pwdata[`TSC_ST_ALARM_ACTIVE]) begin
            nxt_status.alarmActive = 1'b0;
         end
      end
      if (rdStat) begin
         nxt_status.newSampleFlag = 1'b0;
      end
      // Sets below override clears above
      if (sample) begin
         nxt_status.newSampleFlag = 1'b1;
         if (ctrl_ff.alarmEnable && dataSync >= threshold_ff) begin
            nxt_status.alarmActive = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_ff.maxVal        <= `TSC_RST_MAX;
         status_ff.minVal        <= `TSC_RST_MIN;
         status_ff.newSampleFlag <= 1'b0;
         status_ff.alarmActive   <= 1'b0;
         status_ff.data          <= `TSC_RST_DATA;
      end else begin
         status_ff <= nxt_status;
      end
   end

   // Interrupt pulse on the low-to-high step of the alarm flag only
   always_comb begin
      nxt_irq = 1'b0;
      if (nxt_status.alarmActive && !status_ff.alarmActive) begin
         nxt_irq = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= nxt_irq;
      end
   end

   // Bus answer
   always_comb begin
      nxt_prdata  = prdata_ff;
      nxt_pready  = access;
      nxt_pslverr = 1'b0;
      if (access) begin
         nxt_pslverr = (sel == tsc_pkg::TSC_SEL_NONE);
         nxt_prdata  = 32'h0000_0000;
         if (!pwrite) begin
            case (sel)
               tsc_pkg::TSC_SEL_CTRL: begin
                  nxt_prdata = ctrlWord(ctrl_ff);
               end
               tsc_pkg::TSC_SEL_STATUS: begin
                  nxt_prdata = statusWord(status_ff, sclk_ff);
               end
               tsc_pkg::TSC_SEL_THRESHOLD: begin
                  nxt_prdata[`TSC_THR_HI:`TSC_THR_LO] = threshold_ff;
               end
               default: begin
                  nxt_prdata = 32'h0000_0000;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         prdata_ff  <= nxt_prdata;
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   assign prdata         = prdata_ff;
   assign pready         = pready_ff;
   assign pslverr        = pslverr_ff;
   assign irq            = irq_ff;
   assign sensorClk      = sclk_ff;
   assign sensorRstN     = ctrl_ff.sensorRstN;
   assign sensorPdN      = ctrl_ff.powerUpN;
   assign sensorDcorrect = ctrl_ff.dcorrect;

endmodule

// ---- tsc_temp_sensor_asserts.sv ----
`timescale 1ns/1ps
module tsc_temp_sensor_asserts (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sensorClk,
   input wire logic        irq
);
   logic rdStat;
   assign rdStat = pready && !pwrite && paddr == 8'h04;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   wait_state_a: assert property (psel && penable && !pready |=> pready)
      else $error("no ready after one wait");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready too long");
   map_err_a: assert property (pready |->
      pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
      else $error("bad error response");
   err_data_a: assert property (pslverr |-> prdata == 32'h0000_0000)
      else $error("data on error");
   stat_rsvd_a: assert property (rdStat |-> !prdata[31] &&
      !prdata[23] && prdata[14:10] == 5'h00 && !prdata[7])
      else $error("status reserved bit set");
   thr_rsvd_a: assert property (pready && !pwrite && paddr == 8'h08
      |-> prdata[31:7] == 25'h000_0000)
      else $error("threshold reserved bit set");
   sclk_live_a: assert property (rdStat |-> prdata[15] == $past(sensorClk))
      else $error("clock bit stale");
   irq_pulse_a: assert property (irq |=> !irq)
      else $error("irq held");
   rdata_hold_a: assert property ($changed(prdata) |-> pready)
      else $error("read data moved");
   cover property ($rose(irq));
   cover property (pready && pslverr);
   cover property (rdStat && prdata[9]);
endmodule

// ---- tsc_sensor_model.sv ----
`timescale 1ns/1ps
module tsc_sensor_model (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               sensorClk,
   input  wire logic               sensorRstN,
   input  wire logic               sensorPdN,
   input  wire tsc_pkg::tsc_temp_t nextSample,
   output tsc_pkg::tsc_temp_t      sensorData,
   output logic                    sensorValid
);
   logic       sclk_ff;
   logic [3:0] edges_ff;
   logic [3:0] hold_ff;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_ff     <= 1'b0;
         edges_ff    <= 4'h0;
         hold_ff     <= 4'h0;
         sensorValid <= 1'b0;
         sensorData  <= 7'h00;
      end else begin
         sclk_ff <= sensorClk;
         if (hold_ff != 4'h0)
            hold_ff <= hold_ff + 4'h1;
         if (hold_ff == 4'h2)
            sensorValid <= 1'b1;
         if (hold_ff == 4'hB) begin
            sensorValid <= 1'b0;
            sensorData  <= ~sensorData; // Released data does not stay valid
         end
         if (!sensorRstN || !sensorPdN)
            edges_ff <= 4'h0;
         else if (sensorClk && !sclk_ff) begin
            edges_ff <= (edges_ff == 4'hB) ? 4'h0 : edges_ff + 4'h1;
            if (edges_ff == 4'hB) begin
               sensorData <= nextSample;
               hold_ff    <= 4'h1;
            end
         end
      end
   end
endmodule

// ---- tsc_temp_sensor_tb.sv ----
`timescale 1ns/1ps
module tsc_temp_sensor_tb;
   localparam tsc_pkg::tsc_temp_t THR = 7'h40;
   logic               clk = 1'b0;
   logic               rst_n = 1'b0;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite = 1'b0;
   logic [7:0]         paddr = 8'h00;
   logic [31:0]        pwdata = 32'h0000_0000;
   logic [31:0]        prdata, rd;
   logic               pready, pslverr, err, sensorValid, sensorClk;
   logic               sensorRstN, sensorPdN, irq, sq, prevAl;
   logic               eAl = 1'b0;
   logic               eAlen = 1'b0;
   logic [7:0]         lf = 8'h36;
   logic [4:0]         dcor;
   tsc_pkg::tsc_temp_t sensorData, s, eMax, eMin;
   tsc_pkg::tsc_temp_t nextSample = 7'h7F;
   int                 n_errors = 0;
   int                 cmp_count = 0;
   int                 cyc = 0, run = 0, per = 0, nIrq = 0, eIrq = 0, i;

   always #4 clk = ~clk;

   tsc_temp_sensor DUT (
      .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .sensorData, .sensorValid, .sensorClk,
      .sensorRstN, .sensorPdN, .sensorDcorrect(dcor), .irq
   );
   tsc_sensor_model u_sensor (
      .clk, .rst_n, .sensorClk, .sensorRstN, .sensorPdN, .nextSample,
      .sensorData, .sensorValid
   );

   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   function automatic logic [31:0] st(input logic new_sample_flag);
      return {1'b0, eMax, 1'b0, eMin, 6'h00, new_sample_flag, eAl, 1'b0, s};
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (n_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && k < 8) begin
         @(posedge clk);
         k++;
      end
      if (k == 8)
         n_errors++;
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      sq  <= sensorClk;
      run <= (sensorClk && !sq) ? 1 : run + 1;
      if (sensorClk && !sq)
         per <= run;
      if (irq === 1'b1)
         nIrq <= nIrq + 1;
      if (cyc == 5000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, 8'h04, 32'h0);
      check(rd, 32'h007F_0000);
      apb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0000_0000);
      apb(1'b1, 8'h08, 32'hFFFF_FFC0);
      apb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0000_0040);
      apb(1'b0, 8'h0C, 32'h0);
      check({31'h0, err}, 32'h0000_0001);
      apb(1'b1, 8'h04, 32'h5522_0400);
      apb(1'b1, 8'h04, 32'h1111_0000);
      apb(1'b0, 8'h04, 32'h0);
      check(rd, 32'h5522_0000);
      eMax = 7'h55;
      eMin = 7'h22;
      eAlen = 1'b1;
      apb(1'b1, 8'h00, {23'h000_100, 1'b1, 8'h8F});
      apb(1'b0, 8'h00, 32'h0);
      check(rd, 32'h0002_018F);
      check({25'h0, dcor, sensorRstN, sensorPdN}, 32'h0000_000F);
      for (i = 0; i < 14; i++) begin
         case (i)
            0: s = 7'h7F;
            1: s = 7'h00;
            2: s = 7'h3F;
            3: s = THR;
            6: s = 7'h7E;
            default: begin
               lf = lfsr(lf);
               s = lf[6:0];
            end
         endcase
         if (i == 6 || i == 9) begin
            eAlen = (i == 9);
            apb(1'b1, 8'h00, {23'h000_100, eAlen, 8'h8F});
         end
         nextSample <= s;
         while (sensorValid !== 1'b1 && cyc < 5000)
            @(posedge clk);
         repeat (8) @(posedge clk);
         prevAl = eAl;
         if (eAlen && s >= THR)
            eAl = 1'b1;
         if (eAl && !prevAl)
            eIrq++;
         if (s > eMax)
            eMax = s;
         if (s < eMin)
            eMin = s;
         apb(1'b0, 8'h04, 32'h0);
         check(rd & 32'hFFFF_7FFF, st(1'b1));
         check(nIrq, eIrq);
         apb(1'b0, 8'h04, 32'h0);
         check(rd & 32'hFFFF_7FFF, st(1'b0));
         apb(1'b1, 8'h04, (i % 3 == 2) ? 32'h0000_0100 : 32'h0000_02FF);
         if (i % 3 == 2)
            eAl = 1'b0;
      end
      check(per, 4);
      tally_and_finish();
   end
endmodule

bind tsc_temp_sensor tsc_temp_sensor_asserts u_chk (
   .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
   .pslverr, .sensorClk, .irq
);
